// *** shared/mie_pkg.sv ***
// Constants and types for the instruction execution core
package mie_pkg;
  // ==========================================
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int PHASES = 4;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  // ==========================================
  // Instruction word layout
  localparam int IW = 14;
  localparam logic [2:0] CL_MEM = 3'h0;
  localparam logic [2:0] CL_UNA = 3'h1;
  localparam logic [2:0] CL_IMM = 3'h2;
  localparam logic [2:0] CL_MISC = 3'h3;
  localparam logic [2:0] CL_JMP = 3'h4;
  localparam logic [2:0] CL_CALL = 3'h5;
  localparam logic [2:0] CL_BIT0 = 3'h6;
  localparam logic [2:0] CL_BIT1 = 3'h7;
  typedef enum logic [3:0] {
    M_MOVA, M_MOVM, M_ADD, M_ADDM, M_ADC, M_ADCM, M_SUB, M_SUBM,
    M_SBC, M_SBCM, M_AND, M_ANDM, M_OR, M_ORM, M_XOR, M_XORM
  } mie_mfn_t;
  typedef enum logic [3:0] {
    U_CPL, U_CPLA, U_INC, U_INCREMENT_TO_ACCUMULATOR, U_DEC, U_DECREMENT_TO_ACCUMULATOR, U_RR, U_RRA,
    U_RL, U_RLA, U_RRC, U_RRCA, U_RLC, U_RLCA, U_SZ, U_TABRD
  } mie_ufn_t;
  typedef enum logic [2:0] {
    I_MOV, I_ADD, I_SUB, I_AND, I_OR, I_XOR, I_RETV, I_NOP
  } mie_ifn_t;
  typedef enum logic [2:0] {
    X_NOP, X_RET, X_INTERRUPT_RETURN, X_HALT, X_CLRWDT, X_R5, X_R6, X_R7
  } mie_xfn_t;
  typedef enum logic [1:0] {B_CLR, B_SET, B_SZ, B_SNZ} mie_bfn_t;
  // ==========================================
  // Flags and special data locations
  localparam int F_Z = 0;
  localparam int F_C = 1;
  localparam int F_AC = 2;
  localparam int F_OV = 3;
  localparam logic [6:0] PCL_ADDR = 7'h06;
  localparam logic [6:0] TBLP_ADDR = 7'h07;
  localparam logic [13:0] IR_RST = 14'h1f00;
  // ==========================================
  // Register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PC = 8'h08;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_WAKE = 1;
  localparam logic RUN_RST = 1'b0;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [1:0] {
    ST_EXEC = 2'b00, ST_FLUSH = 2'b01, ST_TABLE = 2'b11, ST_HALT = 2'b10
  } mie_st_t;
endpackage

// *** src/mie_core.sv ***
// Instruction execution core with AXI4-Lite control registers
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mie_core #(
  parameter int PC_W = 11,
  parameter int DM_AW = 7,
  parameter int STACK_D = 2
) (
  input wire logic i_clk, // System clock
  input wire logic i_rst_n, // Sync reset, active low
  input wire logic [7:0] i_awaddr, // AXI write address
  input wire logic i_awvalid, // AXI write address valid
  output logic o_awready, // AXI write address ready
  input wire logic [31:0] i_wdata, // AXI write data
  input wire logic [3:0] i_wstrb, // AXI write strobes
  input wire logic i_wvalid, // AXI write data valid
  output logic o_wready, // AXI write data ready
  output logic [1:0] o_bresp, // AXI write response
  output logic o_bvalid, // AXI write response valid
  input wire logic i_bready, // AXI write response ready
  input wire logic [7:0] i_araddr, // AXI read address
  input wire logic i_arvalid, // AXI read address valid
  output logic o_arready, // AXI read address ready
  output logic [31:0] o_rdata, // AXI read data
  output logic [1:0] o_rresp, // AXI read response
  output logic o_rvalid, // AXI read data valid
  input wire logic i_rready, // AXI read data ready
  output logic [PC_W-1:0] o_pm_addr, // Program memory address
  input wire logic [13:0] i_pm_data, // Program memory word
  output logic [DM_AW-1:0] o_dm_raddr, // Data memory read address
  input wire logic [7:0] i_dm_rdata, // Data memory read data
  output logic [DM_AW-1:0] o_dm_waddr, // Data memory write address
  output logic [7:0] o_dm_wdata, // Data memory write data
  output logic o_dm_we, // Data memory write strobe
  output logic o_halt, // Power-down requested
  output logic o_wdt_clr // Watchdog clear pulse
);
  // ==========================================
  // Add/subtract: returns {ov, ac, c, result}
  function automatic logic [10:0] addsub(input logic [7:0] a,
      input logic [7:0] b, input logic ci, input logic sub);
    logic [8:0] s;
    logic [4:0] n;
    logic ov;
    s = sub ? {1'b0, a} - {1'b0, b} - {8'h0, ci}
            : {1'b0, a} + {1'b0, b} + {8'h0, ci};
    n = sub ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci}
            : {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    ov = sub ? (a[7] != b[7]) && (s[7] != a[7])
             : (a[7] == b[7]) && (s[7] != a[7]);
    return {ov, n[4], s[8], s[7:0]};
  endfunction

  // ==========================================
  // Core state
  logic [1:0] phase, next_phase;
  mie_pkg::mie_st_t st, next_st;
  logic [PC_W-1:0] pc, next_pc, next_pm_addr;
  logic [13:0] ir, next_ir;
  logic [7:0] acc, next_acc, tblp, next_tblp;
  logic [5:0] tblh, next_tblh;
  logic [3:0] flg, next_flg;
  logic [PC_W-1:0] stk [STACK_D], next_stk [STACK_D];
  logic [DM_AW-1:0] next_dm_raddr, next_dm_waddr;
  logic [7:0] next_dm_wdata;
  logic next_dm_we, next_halt, next_wdt_clr;
  logic ctrl_run, halt_rel;
  logic inst_en, exec_now;
  // Decode scratch
  logic [7:0] mv, res;
  logic [10:0] as;
  logic wr_mem, wr_acc, upd_z, upd_arith, skip, jump, push, pop;
  logic [PC_W-1:0] jaddr;
  logic [2:0] cls;
  logic [3:0] fn;

  assign inst_en = (phase == mie_pkg::PHASE_LAST);
  assign exec_now = inst_en && ctrl_run && st == mie_pkg::ST_EXEC;
  assign cls = ir[13:11];
  assign fn = ir[10:7];

  always_comb begin
    next_phase = phase + 2'h1;
    next_st = st;
    next_pc = pc;
    next_pm_addr = o_pm_addr;
    next_ir = ir;
    next_acc = acc;
    next_tblp = tblp;
    next_tblh = tblh;
    next_flg = flg;
    next_stk = stk;
    next_dm_raddr = o_dm_raddr;
    next_dm_waddr = o_dm_waddr;
    next_dm_wdata = o_dm_wdata;
    next_dm_we = 1'b0;
    next_wdt_clr = 1'b0;
    // PROGRAM_COUNTER_LOW_BYTE reads back the low byte of the executing address
    mv = (o_dm_raddr == DM_AW'(mie_pkg::PCL_ADDR)) ?
         pc[7:0] - 8'h01 : i_dm_rdata;
    res = mv;
    as = '0;
    {wr_mem, wr_acc, upd_z, upd_arith} = 4'h0;
    {skip, jump, push, pop} = 4'h0;
    jaddr = ir[PC_W-1:0];
    if (st == mie_pkg::ST_HALT && halt_rel) begin
      next_st = mie_pkg::ST_EXEC;
    end
    if (inst_en && ctrl_run && st == mie_pkg::ST_TABLE) begin
      next_acc = i_pm_data[7:0];
      next_tblh = i_pm_data[13:8];
      next_pm_addr = pc;
      next_st = mie_pkg::ST_EXEC;
    end
    if (inst_en && ctrl_run && st[1] == 1'b0) begin
      // Fetch the next word; in FLUSH the old ir is simply dropped
      next_ir = i_pm_data;
      next_pc = PC_W'(pc + 1'b1);
      next_pm_addr = PC_W'(pc + 1'b1);
      next_dm_raddr = i_pm_data[DM_AW-1:0];
      next_st = mie_pkg::ST_EXEC;
    end
    if (exec_now) begin
      unique case (cls)
        mie_pkg::CL_MEM: begin
          wr_mem = fn[0];
          wr_acc = !fn[0];
          if (fn[3:1] == 3'h0) begin
            res = fn[0] ? acc : mv;
          end else if (fn < 4'ha) begin
            as = addsub(acc, mv, (fn[3:1] == 3'h2 || fn[3:1] == 3'h4)
                 && flg[mie_pkg::F_C], fn[3:1] > 3'h2);
            res = as[7:0];
            upd_arith = 1'b1;
          end else begin
            unique case (fn[2:1])
              2'h1: res = acc & mv;
              2'h2: res = acc | mv;
              default: res = acc ^ mv;
            endcase
            upd_z = 1'b1;
          end
        end
        mie_pkg::CL_UNA: begin
          wr_mem = !fn[0] && fn < 4'he;
          wr_acc = fn[0] && fn < 4'he;
          unique case (fn[3:1])
            3'h0: begin res = ~mv; upd_z = 1'b1; end
            3'h1: begin res = mv + 8'h01; upd_z = 1'b1; end
            3'h2: begin res = mv - 8'h01; upd_z = 1'b1; end
            3'h3: res = {mv[0], mv[7:1]};
            3'h4: res = {mv[6:0], mv[7]};
            3'h5: begin
              res = {flg[mie_pkg::F_C], mv[7:1]};
              next_flg[mie_pkg::F_C] = mv[0];
            end
            3'h6: begin
              res = {mv[6:0], flg[mie_pkg::F_C]};
              next_flg[mie_pkg::F_C] = mv[7];
            end
            default: begin
              if (fn[0]) begin
                // Table cycle borrows the fetch port for one cycle
                next_st = mie_pkg::ST_TABLE;
                next_pm_addr = {pc[PC_W-1:8], tblp};
              end else begin
                skip = (mv == 8'h00);
              end
            end
          endcase
        end
        mie_pkg::CL_IMM: begin
          wr_acc = fn[3:1] != 3'h7;
          unique case (fn[3:1])
            3'h0: res = ir[7:0];
            3'h1, 3'h2: begin
              as = addsub(acc, ir[7:0], 1'b0, fn[3:1] == 3'h2);
              res = as[7:0];
              upd_arith = 1'b1;
            end
            3'h3: begin res = acc & ir[7:0]; upd_z = 1'b1; end
            3'h4: begin res = acc | ir[7:0]; upd_z = 1'b1; end
            3'h5: begin res = acc ^ ir[7:0]; upd_z = 1'b1; end
            3'h6: begin res = ir[7:0]; pop = 1'b1; end
            default: res = acc;
          endcase
        end
        mie_pkg::CL_MISC: begin
          unique case (fn[3:1])
            3'h1, 3'h2: pop = 1'b1;
            3'h3: next_st = mie_pkg::ST_HALT;
            3'h4: next_wdt_clr = 1'b1;
            default: res = mv;
          endcase
        end
        mie_pkg::CL_JMP: jump = 1'b1;
        mie_pkg::CL_CALL: begin
          jump = 1'b1;
          push = 1'b1;
        end
        mie_pkg::CL_BIT0, mie_pkg::CL_BIT1: begin
          unique case (ir[11:10])
            2'h0: res = mv & ~(8'h01 << ir[9:7]);
            2'h1: res = mv | (8'h01 << ir[9:7]);
            2'h2: skip = !mv[ir[9:7]];
            default: skip = mv[ir[9:7]];
          endcase
          wr_mem = !ir[11];
        end
      endcase
      if (upd_arith) begin
        next_flg = {as[10:8], res == 8'h00};
      end
      if (upd_z) begin
        next_flg[mie_pkg::F_Z] = (res == 8'h00);
      end
      if (wr_acc) begin
        next_acc = res;
      end
      if (wr_mem) begin
        next_dm_we = 1'b1;
        next_dm_waddr = ir[DM_AW-1:0];
        next_dm_wdata = res;
        if (ir[DM_AW-1:0] == DM_AW'(mie_pkg::TBLP_ADDR)) begin
          next_tblp = res;
        end
        if (ir[DM_AW-1:0] == DM_AW'(mie_pkg::PCL_ADDR)) begin
          jump = 1'b1;
          jaddr = {pc[PC_W-1:8], res};
        end
      end
      if (pop) begin
        jump = 1'b1;
        jaddr = stk[0];
        for (int i = 0; i < STACK_D - 1; i++) begin
          next_stk[i] = stk[i+1];
        end
      end
      if (push) begin
        next_stk[0] = pc;
        for (int i = 1; i < STACK_D; i++) begin
          next_stk[i] = stk[i-1];
        end
      end
      if (skip || jump) begin
        next_st = mie_pkg::ST_FLUSH;
      end
      if (jump) begin
        next_pc = jaddr;
        next_pm_addr = jaddr;
      end
    end
    next_halt = (next_st == mie_pkg::ST_HALT);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      phase <= 2'h0;
      st <= mie_pkg::ST_FLUSH;
      pc <= '0;
      o_pm_addr <= '0;
      ir <= mie_pkg::IR_RST;
      acc <= 8'h00;
      tblp <= 8'h00;
      tblh <= 6'h00;
      flg <= 4'h0;
      for (int i = 0; i < STACK_D; i++) begin
        stk[i] <= '0;
      end
      o_dm_raddr <= '0;
      o_dm_waddr <= '0;
      o_dm_wdata <= 8'h00;
      o_dm_we <= 1'b0;
      o_halt <= 1'b0;
      o_wdt_clr <= 1'b0;
    end else begin
      phase <= next_phase;
      st <= next_st;
      pc <= next_pc;
      o_pm_addr <= next_pm_addr;
      ir <= next_ir;
      acc <= next_acc;
      tblp <= next_tblp;
      tblh <= next_tblh;
      flg <= next_flg;
      stk <= next_stk;
      o_dm_raddr <= next_dm_raddr;
      o_dm_waddr <= next_dm_waddr;
      o_dm_wdata <= next_dm_wdata;
      o_dm_we <= next_dm_we;
      o_halt <= next_halt;
      o_wdt_clr <= next_wdt_clr;
    end
  end

  // ==========================================
  // AXI4-Lite slave
  logic aw_full, next_aw_full, w_full, next_w_full;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic w_strb0, next_w_strb0;
  logic next_run, next_rel, next_awrdy, next_wrdy, next_arrdy;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;

  always_comb begin
    next_aw_full = aw_full;
    next_w_full = w_full;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb0 = w_strb0;
    next_run = ctrl_run;
    next_rel = 1'b0;
    next_bvalid = o_bvalid;
    next_bresp = o_bresp;
    next_rvalid = o_rvalid;
    next_rresp = o_rresp;
    next_rdata = o_rdata;
    if (i_awvalid && o_awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      next_w_full = 1'b1;
      next_w_data = i_wdata;
      next_w_strb0 = i_wstrb[0];
    end
    if (o_bvalid && i_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_full && w_full && !o_bvalid) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mie_pkg::RESP_OK;
      if (aw_addr[7:2] == mie_pkg::REG_CTRL[7:2]) begin
        if (w_strb0) begin
          next_run = w_data[mie_pkg::CTRL_RUN];
          next_rel = w_data[mie_pkg::CTRL_WAKE];
        end
      end else if (aw_addr[7:2] != mie_pkg::REG_STATUS[7:2] &&
                   aw_addr[7:2] != mie_pkg::REG_PC[7:2]) begin
        next_bresp = mie_pkg::RESP_ERR;
      end
    end
    if (o_rvalid && i_rready) begin
      next_rvalid = 1'b0;
    end
    if (i_arvalid && o_arready) begin
      next_rvalid = 1'b1;
      next_rresp = mie_pkg::RESP_OK;
      unique case (i_araddr[7:2])
        mie_pkg::REG_CTRL[7:2]: next_rdata = {31'h0, ctrl_run};
        mie_pkg::REG_STATUS[7:2]:
          next_rdata = {10'h0, tblh, 3'h0, o_halt, flg, acc};
        mie_pkg::REG_PC[7:2]: next_rdata = 32'(pc);
        default: begin
          next_rdata = 32'h0;
          next_rresp = mie_pkg::RESP_ERR;
        end
      endcase
    end
    next_awrdy = !next_aw_full;
    next_wrdy = !next_w_full;
    next_arrdy = !next_rvalid;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb0 <= 1'b0;
      ctrl_run <= mie_pkg::RUN_RST;
      halt_rel <= 1'b0;
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_arready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= mie_pkg::RESP_OK;
      o_rvalid <= 1'b0;
      o_rresp <= mie_pkg::RESP_OK;
      o_rdata <= 32'h0;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb0 <= next_w_strb0;
      ctrl_run <= next_run;
      halt_rel <= next_rel;
      o_awready <= next_awrdy;
      o_wready <= next_wrdy;
      o_arready <= next_arrdy;
      o_bvalid <= next_bvalid;
      o_bresp <= next_bresp;
      o_rvalid <= next_rvalid;
      o_rresp <= next_rresp;
      o_rdata <= next_rdata;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic add_cy, plain_mem;
  assign add_cy = ({1'b0, acc} + {1'b0, i_dm_rdata}) > 9'h0ff;
  assign plain_mem = (o_dm_raddr != DM_AW'(mie_pkg::PCL_ADDR));

  phase_four_a: assert property (inst_en |=> !inst_en [*3] ##1 inst_en)
    else $error("instruction cycle is not four clocks");
  jump_flush_a: assert property (exec_now && cls == mie_pkg::CL_JMP
    |=> st == mie_pkg::ST_FLUSH && pc == $past(ir[PC_W-1:0]))
    else $error("jump did not take the flush cycle");
  pcl_write_a: assert property (exec_now && cls == mie_pkg::CL_MEM
    && fn == 4'h1 && ir[DM_AW-1:0] == DM_AW'(mie_pkg::PCL_ADDR)
    |=> st == mie_pkg::ST_FLUSH && pc[7:0] == $past(acc))
    else $error("PROGRAM_COUNTER_LOW_BYTE write did not redirect");
  skip_cost_a: assert property (exec_now && skip
    |=> st == mie_pkg::ST_FLUSH ##4 st == mie_pkg::ST_EXEC)
    else $error("taken skip not two cycles");
  add_carry_a: assert property (exec_now && cls == mie_pkg::CL_MEM
    && fn == 4'h2 && plain_mem |=> flg[mie_pkg::F_C] == $past(add_cy))
    else $error("add carry wrong");
  inc_acc_a: assert property (exec_now && cls == mie_pkg::CL_UNA
    && fn == 4'h3 && plain_mem |=> acc == $past(i_dm_rdata) + 8'h01)
    else $error("increment to acc wrong");
  zero_flag_a: assert property (exec_now && upd_z && wr_acc
    |=> flg[mie_pkg::F_Z] == (acc == 8'h00))
    else $error("zero flag wrong");
  call_save_a: assert property (exec_now && cls == mie_pkg::CL_CALL
    |=> stk[0] == $past(pc) && o_pm_addr == $past(ir[PC_W-1:0]))
    else $error("call did not save return address");
  table_cyc_a: assert property (exec_now && next_st == mie_pkg::ST_TABLE
    |=> st == mie_pkg::ST_TABLE [*4] ##1 acc == $past(i_pm_data[7:0]))
    else $error("table read not delivered");
  halt_out_a: assert property (exec_now && cls == mie_pkg::CL_MISC
    && fn[3:1] == 3'h3 |=> o_halt)
    else $error("halt not signalled");
  flush_quiet_a: assert property (st == mie_pkg::ST_FLUSH
    |=> !o_dm_we)
    else $error("discarded word wrote memory");
  skip_taken_c: cover property (exec_now && skip);
  call_ret_c: cover property (exec_now && push ##[1:200] exec_now && pop);
  table_read_c: cover property (st == mie_pkg::ST_TABLE);
  axi_write_c: cover property (o_bvalid && i_bready);
endmodule
`default_nettype wire

// *** tb/mie_mem_model.sv ***
// Program and data memory model facing the execution core
`timescale 1ns/1ps
`default_nettype none
module mie_mem_model #(
  parameter int PC_W = 11,
  parameter int DM_AW = 7,
  parameter int LAT = 1
) (
  input wire logic i_clk, // System clock
  input wire logic [PC_W-1:0] i_pm_addr, // Program fetch address
  output logic [13:0] o_pm_data, // Program word
  input wire logic [DM_AW-1:0] i_dm_raddr, // Data read address
  output logic [7:0] o_dm_rdata, // Data read value
  input wire logic [DM_AW-1:0] i_dm_waddr, // Data write address
  input wire logic [7:0] i_dm_wdata, // Data write value
  input wire logic i_dm_we // Data write strobe
);
  logic [13:0] pm [2**PC_W];
  logic [7:0] dm [2**DM_AW];
  logic [13:0] pm_q;
  logic [7:0] dm_q;
  always @(posedge i_clk) begin
    pm_q <= pm[i_pm_addr];
    dm_q <= dm[i_dm_raddr];
    if (i_dm_we) begin
      dm[i_dm_waddr] <= i_dm_wdata;
    end
  end
  // A clock of read latency uses up part of the core's slack
  assign o_pm_data = (LAT == 0) ? pm[i_pm_addr] : pm_q;
  assign o_dm_rdata = (LAT == 0) ? dm[i_dm_raddr] : dm_q;
  task automatic clear();
    for (int k = 0; k < 2**PC_W; k++) pm[k] = 14'h0000;
    for (int k = 0; k < 2**DM_AW; k++) dm[k] = 8'h00;
  endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the instruction execution core
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, halt, wdt_clr, dm_we;
  logic [7:0] awaddr, araddr, dm_rdata, dm_wdata;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [10:0] pm_addr;
  logic [13:0] pm_data;
  logic [6:0] dm_raddr, dm_waddr;
  logic [13:0] p [$];
  logic [2:0] rt [2];
  int err_total, n_checks, base, wdt_n;
  localparam logic [13:0] HLT = {mie_pkg::CL_MISC, 3'h3, 8'h00};
  mie_core i_mie_core (.i_clk(clk), .i_rst_n(rst_n), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .o_pm_addr(pm_addr), .i_pm_data(pm_data),
    .o_dm_raddr(dm_raddr), .i_dm_rdata(dm_rdata), .o_dm_waddr(dm_waddr),
    .o_dm_wdata(dm_wdata), .o_dm_we(dm_we), .o_halt(halt),
    .o_wdt_clr(wdt_clr));
  mie_mem_model i_mie_mem_model (.i_clk(clk), .i_pm_addr(pm_addr),
    .o_pm_data(pm_data), .i_dm_raddr(dm_raddr), .o_dm_rdata(dm_rdata),
    .i_dm_waddr(dm_waddr), .i_dm_wdata(dm_wdata), .i_dm_we(dm_we));
  // ==========================================
  // Word builders
  function automatic logic [13:0] im(logic [2:0] f, logic [7:0] x);
    return {mie_pkg::CL_IMM, f, x};
  endfunction
  function automatic logic [13:0] wi(logic [2:0] c, f, logic [7:0] x);
    return {c, f, x};
  endfunction
  function automatic logic [13:0] wm(logic [3:0] f, logic [6:0] m);
    return {mie_pkg::CL_MEM, f, m};
  endfunction
  function automatic logic [13:0] un(logic [3:0] f, logic [6:0] m);
    return {mie_pkg::CL_UNA, f, m};
  endfunction
  function automatic logic [13:0] wb(logic [1:0] f, logic [2:0] b);
    return {2'b11, f, b, 7'h20};
  endfunction
  // ==========================================
  // Bus and check tasks
  task automatic chk(input logic [33:0] g, e, input string s);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, s, g, e);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v,
                     output logic [1:0] r);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 || awvalid || wvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // Load, restart, let it run to the power-down, then compare timing
  task automatic run(input string nm, input int cyc, input logic [31:0] e, m);
    logic [31:0] v;
    logic [1:0] r;
    int n;
    i_mie_mem_model.clear();
    foreach (p[k]) i_mie_mem_model.pm[k] = p[k];
    wdt_n = 0;
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    axw(mie_pkg::REG_CTRL, 32'h1, r);
    n = 0;
    while (halt !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (cyc == 0) base = n;
    chk(34'(n), 34'(base + 4 * cyc), {nm, " clocks"});
    axr(mie_pkg::REG_STATUS, v, r);
    chk({2'b00, v & m}, {2'b00, e}, {nm, " status"});
    $display("test %s done", nm);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========================================
  // Clock, watchdog, sequence
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wdt_clr === 1'b1) wdt_n <= wdt_n + 1;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    results();
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, rst_n} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    {err_total, n_checks, base, wdt_n} = '0;
    rt = '{mie_pkg::X_RET, mie_pkg::X_INTERRUPT_RETURN};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    axr(mie_pkg::REG_CTRL, d, resp);
    chk({resp, d}, {mie_pkg::RESP_OK, 32'h0}, "ctrl reset");
    axr(8'h0c, d, resp);
    chk({resp, d}, {mie_pkg::RESP_ERR, 32'h0}, "unmapped read");
    axw(8'h10, 32'h1, resp);
    chk({resp, 32'h0}, {mie_pkg::RESP_ERR, 32'h0}, "unmapped write");
    axw(mie_pkg::REG_STATUS, 32'hffffffff, resp);
    chk({resp, 32'h0}, {mie_pkg::RESP_OK, 32'h0}, "read-only write");
    p = '{HLT};
    run("base", 0, 32'h1000, 32'h1000);
    p = '{im(mie_pkg::I_MOV, 8'hff), im(mie_pkg::I_ADD, 8'h02), HLT};
    run("add carry", 2, 32'h1601, 32'h1fff);
    p = '{im(mie_pkg::I_MOV, 8'h7f), im(mie_pkg::I_ADD, 8'h01), HLT};
    run("add overflow", 2, 32'h1c80, 32'h1fff);
    p = '{im(mie_pkg::I_MOV, 8'h00), im(mie_pkg::I_SUB, 8'h01), HLT};
    run("sub borrow", 2, 32'h12ff, 32'h1bff);
    p = '{im(mie_pkg::I_MOV, 8'hf0), im(mie_pkg::I_AND, 8'h0f), HLT};
    run("and zero", 2, 32'h1100, 32'h11ff);
    p = '{im(mie_pkg::I_MOV, 8'h02), wm(mie_pkg::M_MOVM, 7'h20),
          im(mie_pkg::I_MOV, 8'hff), wm(mie_pkg::M_ADD, 7'h20), HLT};
    run("mem add", 4, 32'h1601, 32'h1fff);
    p = '{im(mie_pkg::I_MOV, 8'h41), wm(mie_pkg::M_MOVM, 7'h20),
          un(mie_pkg::U_INCREMENT_TO_ACCUMULATOR, 7'h20), HLT};
    run("inc to acc", 3, 32'h1042, 32'h10ff);
    p = '{im(mie_pkg::I_MOV, 8'h81), im(mie_pkg::I_ADD, 8'h00),
          wm(mie_pkg::M_MOVM, 7'h20), un(mie_pkg::U_RLCA, 7'h20), HLT};
    run("rotate", 4, 32'h1202, 32'h12ff);
    chk(34'(i_mie_mem_model.dm[32]), 34'h81, "rotate source");
    p = '{im(mie_pkg::I_MOV, 8'h5a), wm(mie_pkg::M_MOVM, 7'h20),
          un(mie_pkg::U_INC, 7'h20), wb(mie_pkg::B_SET, 3'h7),
          wb(mie_pkg::B_CLR, 3'h1), wm(mie_pkg::M_MOVA, 7'h20), HLT};
    run("bits", 6, 32'h10d9, 32'h10ff);
    p = '{im(mie_pkg::I_MOV, 8'h33), wi(mie_pkg::CL_JMP, 3'h0, 8'h03),
          wm(mie_pkg::M_MOVM, 7'h20), HLT};
    run("jump", 3, 32'h1033, 32'h10ff);
    chk(34'(i_mie_mem_model.dm[32]), 34'h0, "dropped word");
    p = '{wi(mie_pkg::CL_CALL, 3'h0, 8'h04), HLT, im(mie_pkg::I_MOV, 8'h11),
          HLT, im(mie_pkg::I_RETV, 8'h3c)};
    run("return value", 4, 32'h103c, 32'h10ff);
    foreach (rt[k]) begin
      p = '{im(mie_pkg::I_MOV, 8'h22), wi(mie_pkg::CL_CALL, 3'h0, 8'h05),
            HLT, im(mie_pkg::I_MOV, 8'h11), HLT, wi(mie_pkg::CL_MISC, rt[k],
            8'h00)};
      run("return", 5, 32'h1022, 32'h10ff);
    end
    p = '{im(mie_pkg::I_MOV, 8'h22), un(mie_pkg::U_SZ, 7'h20),
          im(mie_pkg::I_MOV, 8'h11), HLT};
    run("skip taken", 3, 32'h1022, 32'h10ff);
    p = '{im(mie_pkg::I_MOV, 8'h22), wm(mie_pkg::M_MOVM, 7'h20),
          wb(mie_pkg::B_SZ, 3'h1), im(mie_pkg::I_MOV, 8'h11), HLT};
    run("bit no skip", 4, 32'h1011, 32'h10ff);
    p[2] = wb(mie_pkg::B_SNZ, 3'h1);
    run("bit skip", 4, 32'h1022, 32'h10ff);
    p = '{im(mie_pkg::I_MOV, 8'h03), wm(mie_pkg::M_MOVM, mie_pkg::PCL_ADDR),
          im(mie_pkg::I_MOV, 8'h11), HLT};
    run("low pc write", 3, 32'h1003, 32'h10ff);
    p = '{im(mie_pkg::I_MOV, 8'h04), wm(mie_pkg::M_MOVM, mie_pkg::TBLP_ADDR),
          un(mie_pkg::U_TABRD, 7'h20), HLT, 14'h2a5b};
    run("table", 4, 32'h2a105b, 32'h3f10ff);
    p = '{wi(mie_pkg::CL_MISC, mie_pkg::X_CLRWDT, 8'h00), HLT};
    run("watchdog", 1, 32'h1000, 32'h1000);
    chk(34'(wdt_n), 34'h1, "watchdog pulses");
    axw(mie_pkg::REG_CTRL, 32'h3, resp);
    axr(mie_pkg::REG_STATUS, d, resp);
    chk({2'b00, d & 32'h1000}, 34'h0, "wake");
    results();
  end
endmodule
`default_nettype wire
